// ==== ood_pkg.sv ====
package ood_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned BYTE_W = 8;
  localparam int unsigned INSTR_BYTES = 6;
  localparam int unsigned LANES = 4;
  localparam logic [7:0] OFF_INSTR_LO = 8'h00;
  localparam logic [7:0] OFF_INSTR_HI = 8'h04;
  localparam logic [7:0] OFF_BASES = 8'h08;
  localparam logic [7:0] OFF_INDEX = 8'h0c;
  localparam logic [7:0] OFF_COUNT = 8'h10;
  localparam logic [7:0] OFF_CTRL = 8'h14;
  localparam logic [7:0] OFF_FLAGS = 8'h18;
  localparam logic [7:0] OFF_EADDR = 8'h1c;
  localparam logic [7:0] OFF_OPERAND = 8'h20;
  localparam logic [7:0] OFF_STATUS = 8'h24;
  localparam int unsigned CTRL_GO = 0;
  localparam int unsigned CTRL_DONE = 1;
  localparam int unsigned CTRL_RESUME = 2;
  localparam int unsigned POS_OP = 0;
  localparam int unsigned POS_MODRM = 1;
  localparam logic [2:0] POS_DISP = 3'h2;
  localparam int unsigned OPB_W = 0;
  localparam int unsigned OPB_D = 1;
  localparam int unsigned OPB_Z = 0;
  localparam int unsigned SEG_LSB = 3;
  localparam int unsigned COND_LSB = 1;
  localparam logic [7:0] CARRY_CLEAR_OP = 8'hf8;
  localparam logic [7:0] CARRY_INVERT_OP = 8'hf5;
  localparam logic [7:0] CARRY_SET_OP = 8'hf9;
  localparam logic [7:0] DIRECTION_CLEAR_OP = 8'hfc;
  localparam logic [7:0] DIRECTION_SET_OP = 8'hfd;
  localparam logic [7:0] INT_ENABLE_CLEAR_OP = 8'hfa;
  localparam logic [7:0] INT_ENABLE_SET_OP = 8'hfb;
  localparam logic [7:0] HALT_OP = 8'hf4;
  localparam logic [7:0] WAIT_TEST_OP = 8'h9b;
  localparam logic [7:0] LOCK_PREFIX_OP = 8'hf0;
  localparam logic [7:0] MOV_SEG_OP = 8'h8e;
  localparam logic [2:0] MOVSEG_CODE = 3'h1;
  localparam logic [7:0] ESC_MASK = 8'hf8;
  localparam logic [7:0] ESC_PAT = 8'hd8;
  localparam logic [7:0] SEGP_MASK = 8'he7;
  localparam logic [7:0] SEGP_PAT = 8'h26;
  localparam logic [7:0] REPP_MASK = 8'hfe;
  localparam logic [7:0] REPP_PAT = 8'hf2;
  localparam logic [7:0] STRCMP_MASK = 8'hf6;
  localparam logic [7:0] STRCMP_PAT = 8'ha6;
  localparam logic [7:0] QUAD_MASK = 8'hfc;
  localparam logic [7:0] IMM_PAT = 8'h80;
  localparam logic [7:0] SHIFT_PAT = 8'hd0;
  localparam logic [7:0] MOV_PAT = 8'h88;
  localparam logic [7:0] ALU_MASK = 8'hc4;
  localparam logic [7:0] ALU_PAT = 8'h00;
  localparam logic [7:0] JCC_MASK = 8'hf0;
  localparam logic [7:0] JCC_PAT = 8'h70;
  localparam logic [1:0] MOD_NODISP = 2'h0;
  localparam logic [1:0] MOD_DISP8 = 2'h1;
  localparam logic [1:0] MOD_DISP16 = 2'h2;
  localparam logic [1:0] MOD_REG = 2'h3;
  localparam logic [2:0] RM_DIRECT = 3'h6;
  localparam logic [1:0] SW_WORD = 2'h1;
  localparam logic [1:0] SW_SEXT = 2'h3;
  localparam int unsigned FLAG_CARRY = 0;
  localparam int unsigned FLAG_PARITY = 2;
  localparam int unsigned FLAG_AUX = 4;
  localparam int unsigned FLAG_ZERO = 6;
  localparam int unsigned FLAG_SIGN = 7;
  localparam int unsigned FLAG_TRAP = 8;
  localparam int unsigned FLAG_INTEN = 9;
  localparam int unsigned FLAG_DIR = 10;
  localparam int unsigned FLAG_OVF = 11;
  localparam logic [15:0] FLAG_DEFINED = 16'h0fd5;
  localparam logic [15:0] FLAG_RESET = 16'h0000;
  localparam logic [7:0] SHIFT_ONE = 8'h01;

  typedef enum logic [1:0] {RUN_ACTIVE, RUN_HALTED, RUN_WAITING} ood_run_e;

  typedef struct packed {
    logic [1:0] md;
    logic [2:0] rg;
    logic [2:0] rm;
  } ood_modrm_s;

  typedef struct packed {
    logic [15:0] eff_addr;
    logic [15:0] imm_val;
    logic [7:0] shift_count;
    logic [3:0] reg_id;
    logic [3:0] rm_id;
    logic [1:0] disp_len;
    logic [1:0] imm_len;
    logic word_op;
    logic to_reg;
    logic rm_is_reg;
    logic esc_op;
    logic invalid;
    logic jump_taken;
    logic rep_go;
    logic seg_valid;
    logic [1:0] seg;
    logic lock;
    logic step_back;
  } ood_dec_s;
endpackage : ood_pkg

// ==== ood_decoder.sv ====
`timescale 1ns/10ps
module ood_decoder (
  input logic pclk,
  input logic presetn,
  input logic ce,
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [ood_pkg::ADDR_W-1:0] paddr,
  input logic [31:0] pwdata,
  input logic [3:0] pstrb,
  input logic test_ready,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic bus_lock,
  output logic cpu_halted
);
  logic [7:0] ibyte [ood_pkg::INSTR_BYTES];
  logic [15:0] base_register;
  logic [15:0] base_pointer;
  logic [15:0] source_index;
  logic [15:0] destination_index;
  logic [15:0] count_register;
  logic [15:0] processor_flag_word;
  logic [15:0] next_flags;
  ood_pkg::ood_dec_s dec;
  ood_pkg::ood_dec_s next_dec;
  ood_pkg::ood_run_e state;
  ood_pkg::ood_run_e next_state;
  ood_pkg::ood_modrm_s mrm;
  logic [7:0] op;
  logic pend_lock;
  logic pend_seg_v;
  logic [1:0] pend_seg;
  logic pend_rep;
  logic pend_z;
  logic wr_take;
  logic ctrl_wr;
  logic go_ok;
  logic done_wr;
  logic resume_wr;
  logic is_lock;
  logic is_seg;
  logic is_rep;
  logic is_prefix;
  logic has_modrm;
  logic [31:0] next_prdata;
  logic next_slverr;

  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [15:0] wd,
                                          input logic [1:0] st);
    merge16 = old;
    for (int k = 0; k < 2; k++) begin
      if (st[k]) begin
        merge16[k*ood_pkg::BYTE_W +: ood_pkg::BYTE_W] = wd[k*ood_pkg::BYTE_W +: ood_pkg::BYTE_W];
      end
    end
  endfunction : merge16

  assign op = ibyte[ood_pkg::POS_OP];
  assign mrm = ood_pkg::ood_modrm_s'(ibyte[ood_pkg::POS_MODRM]);
  assign wr_take = ce & psel & penable & pready & pwrite;
  assign ctrl_wr = wr_take & (paddr == ood_pkg::OFF_CTRL);
  assign go_ok = ctrl_wr & pwdata[ood_pkg::CTRL_GO] & (state == ood_pkg::RUN_ACTIVE);
  assign done_wr = ctrl_wr & pwdata[ood_pkg::CTRL_DONE];
  assign resume_wr = ctrl_wr & pwdata[ood_pkg::CTRL_RESUME];
  assign is_lock = (op == ood_pkg::LOCK_PREFIX_OP);
  assign is_seg = ((op & ood_pkg::SEGP_MASK) == ood_pkg::SEGP_PAT);
  assign is_rep = ((op & ood_pkg::REPP_MASK) == ood_pkg::REPP_PAT);
  assign is_prefix = is_lock | is_seg | is_rep;
  // forms that carry an addressing byte
  assign has_modrm = ((op & ood_pkg::ALU_MASK) == ood_pkg::ALU_PAT)
                   | ((op & ood_pkg::QUAD_MASK) == ood_pkg::MOV_PAT)
                   | ((op & ood_pkg::QUAD_MASK) == ood_pkg::IMM_PAT)
                   | ((op & ood_pkg::QUAD_MASK) == ood_pkg::SHIFT_PAT)
                   | ((op & ood_pkg::ESC_MASK) == ood_pkg::ESC_PAT)
                   | (op == ood_pkg::MOV_SEG_OP);

  // operand decode
  always_comb begin
    logic [15:0] disp;
    logic [2:0] ipos;
    logic [7:0] ilo;
    logic [7:0] ihi;
    logic [2:0] cc;
    logic ct;
    disp = '0;
    ipos = '0;
    ilo = '0;
    ihi = '0;
    cc = op[ood_pkg::COND_LSB +: 3];
    ct = 1'b0;
    next_dec = '0;
    next_dec.word_op = op[ood_pkg::OPB_W];
    next_dec.to_reg = op[ood_pkg::OPB_D];
    next_dec.esc_op = ((op & ood_pkg::ESC_MASK) == ood_pkg::ESC_PAT);
    next_dec.step_back = processor_flag_word[ood_pkg::FLAG_DIR];
    // word ids 8..15 in register order, byte ids 0..3 low and 4..7 high
    next_dec.reg_id = {next_dec.word_op, mrm.rg};
    if (has_modrm) begin
      next_dec.rm_is_reg = (mrm.md == ood_pkg::MOD_REG);
      if (next_dec.rm_is_reg) begin
        next_dec.rm_id = {next_dec.word_op, mrm.rm};
      end
      case (mrm.md)
        ood_pkg::MOD_NODISP: begin
          if (mrm.rm == ood_pkg::RM_DIRECT) begin
            next_dec.disp_len = 2'h2;
            disp = {ibyte[ood_pkg::POS_DISP+3'h1], ibyte[ood_pkg::POS_DISP]};
          end
        end
        ood_pkg::MOD_DISP8: begin
          next_dec.disp_len = 2'h1;
          disp = {{ood_pkg::BYTE_W{ibyte[ood_pkg::POS_DISP][7]}}, ibyte[ood_pkg::POS_DISP]};
        end
        ood_pkg::MOD_DISP16: begin
          next_dec.disp_len = 2'h2;
          disp = {ibyte[ood_pkg::POS_DISP+3'h1], ibyte[ood_pkg::POS_DISP]};
        end
        default: disp = '0;
      endcase
      if (mrm.md == ood_pkg::MOD_NODISP && mrm.rm == ood_pkg::RM_DIRECT) begin
        next_dec.eff_addr = disp;
      end else begin
        case (mrm.rm)
          3'h0: next_dec.eff_addr = base_register + source_index + disp;
          3'h1: next_dec.eff_addr = base_register + destination_index + disp;
          3'h2: next_dec.eff_addr = base_pointer + source_index + disp;
          3'h3: next_dec.eff_addr = base_pointer + destination_index + disp;
          3'h4: next_dec.eff_addr = source_index + disp;
          3'h5: next_dec.eff_addr = destination_index + disp;
          3'h6: next_dec.eff_addr = base_pointer + disp;
          default: next_dec.eff_addr = base_register + disp;
        endcase
      end
    end
    // immediate sits behind any displacement
    ipos = ood_pkg::POS_DISP + {1'b0, next_dec.disp_len};
    ilo = ibyte[ipos];
    ihi = ibyte[ipos+3'h1];
    if ((op & ood_pkg::QUAD_MASK) == ood_pkg::IMM_PAT) begin
      case (op[ood_pkg::OPB_D -: 2])
        ood_pkg::SW_WORD: begin
          next_dec.imm_len = 2'h2;
          next_dec.imm_val = {ihi, ilo};
        end
        ood_pkg::SW_SEXT: begin
          next_dec.imm_len = 2'h1;
          next_dec.imm_val = {{ood_pkg::BYTE_W{ilo[7]}}, ilo};
        end
        default: begin
          next_dec.imm_len = 2'h1;
          next_dec.imm_val = {8'h00, ilo};
        end
      endcase
    end
    if ((op & ood_pkg::QUAD_MASK) == ood_pkg::SHIFT_PAT) begin
      if (op[ood_pkg::OPB_D]) begin
        next_dec.shift_count = count_register[7:0];
      end else begin
        next_dec.shift_count = ood_pkg::SHIFT_ONE;
      end
    end
    next_dec.invalid = (op == ood_pkg::MOV_SEG_OP) && (mrm.rg == ood_pkg::MOVSEG_CODE);
    if ((op & ood_pkg::JCC_MASK) == ood_pkg::JCC_PAT) begin
      case (cc)
        3'h0: ct = processor_flag_word[ood_pkg::FLAG_OVF];
        3'h1: ct = processor_flag_word[ood_pkg::FLAG_CARRY];
        3'h2: ct = processor_flag_word[ood_pkg::FLAG_ZERO];
        3'h3: ct = processor_flag_word[ood_pkg::FLAG_CARRY]
                 | processor_flag_word[ood_pkg::FLAG_ZERO];
        3'h4: ct = processor_flag_word[ood_pkg::FLAG_SIGN];
        3'h5: ct = processor_flag_word[ood_pkg::FLAG_PARITY];
        3'h6: ct = processor_flag_word[ood_pkg::FLAG_SIGN]
                 ^ processor_flag_word[ood_pkg::FLAG_OVF];
        default: ct = (processor_flag_word[ood_pkg::FLAG_SIGN]
                     ^ processor_flag_word[ood_pkg::FLAG_OVF])
                     | processor_flag_word[ood_pkg::FLAG_ZERO];
      endcase
      next_dec.jump_taken = ct ^ op[ood_pkg::OPB_W];
    end
    if (pend_rep && ((op & ood_pkg::STRCMP_MASK) == ood_pkg::STRCMP_PAT)) begin
      next_dec.rep_go = (pend_z == processor_flag_word[ood_pkg::FLAG_ZERO]);
    end
    next_dec.seg_valid = pend_seg_v;
    next_dec.seg = pend_seg;
    next_dec.lock = pend_lock;
  end

  // flag operations
  always_comb begin
    next_flags = processor_flag_word;
    case (op)
      ood_pkg::CARRY_CLEAR_OP: next_flags[ood_pkg::FLAG_CARRY] = 1'b0;
      ood_pkg::CARRY_INVERT_OP: next_flags[ood_pkg::FLAG_CARRY] =
        ~processor_flag_word[ood_pkg::FLAG_CARRY];
      ood_pkg::CARRY_SET_OP: next_flags[ood_pkg::FLAG_CARRY] = 1'b1;
      ood_pkg::DIRECTION_CLEAR_OP: next_flags[ood_pkg::FLAG_DIR] = 1'b0;
      ood_pkg::DIRECTION_SET_OP: next_flags[ood_pkg::FLAG_DIR] = 1'b1;
      ood_pkg::INT_ENABLE_CLEAR_OP: next_flags[ood_pkg::FLAG_INTEN] = 1'b0;
      ood_pkg::INT_ENABLE_SET_OP: next_flags[ood_pkg::FLAG_INTEN] = 1'b1;
      default: next_flags = processor_flag_word;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      processor_flag_word <= ood_pkg::FLAG_RESET;
    end else if (ce) begin
      if (go_ok) begin
        processor_flag_word <= next_flags;
      end else if (wr_take && paddr == ood_pkg::OFF_FLAGS) begin
        // undefined bits are never stored
        processor_flag_word <= merge16(processor_flag_word, pwdata[15:0],
                                       pstrb[1:0]) & ood_pkg::FLAG_DEFINED;
      end
    end
  end

  always_comb begin
    next_state = state;
    case (state)
      ood_pkg::RUN_ACTIVE: begin
        if (go_ok && op == ood_pkg::HALT_OP) begin
          next_state = ood_pkg::RUN_HALTED;
        end else if (go_ok && op == ood_pkg::WAIT_TEST_OP && !test_ready) begin
          next_state = ood_pkg::RUN_WAITING;
        end
      end
      ood_pkg::RUN_HALTED: begin
        if (resume_wr) begin
          next_state = ood_pkg::RUN_ACTIVE;
        end
      end
      ood_pkg::RUN_WAITING: begin
        if (test_ready) begin
          next_state = ood_pkg::RUN_ACTIVE;
        end
      end
      default: next_state = ood_pkg::RUN_ACTIVE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ood_pkg::RUN_ACTIVE;
      cpu_halted <= 1'b0;
    end else if (ce) begin
      state <= next_state;
      cpu_halted <= (next_state == ood_pkg::RUN_HALTED);
    end
  end

  // prefixes wait for the next non-prefix opcode; a go in the same
  // write as done wins, so a freshly captured lock is not lost
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_lock <= 1'b0;
      pend_seg_v <= 1'b0;
      pend_seg <= '0;
      pend_rep <= 1'b0;
      pend_z <= 1'b0;
      bus_lock <= 1'b0;
      dec <= '0;
    end else if (ce) begin
      if (done_wr) begin
        bus_lock <= 1'b0;
        dec.lock <= 1'b0;
        dec.seg_valid <= 1'b0;
      end
      if (go_ok) begin
        if (is_lock) begin
          pend_lock <= 1'b1;
        end else if (is_seg) begin
          pend_seg_v <= 1'b1;
          pend_seg <= op[ood_pkg::SEG_LSB +: 2];
        end else if (is_rep) begin
          pend_rep <= 1'b1;
          pend_z <= op[ood_pkg::OPB_Z];
        end else begin
          dec <= next_dec;
          bus_lock <= pend_lock;
          pend_lock <= 1'b0;
          pend_seg_v <= 1'b0;
          pend_rep <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int k = 0; k < ood_pkg::INSTR_BYTES; k++) begin
        ibyte[k] <= '0;
      end
      base_register <= '0;
      base_pointer <= '0;
      source_index <= '0;
      destination_index <= '0;
      count_register <= '0;
    end else if (wr_take) begin
      case (paddr)
        ood_pkg::OFF_INSTR_LO, ood_pkg::OFF_INSTR_HI: begin
          for (int k = 0; k < ood_pkg::LANES; k++) begin
            if (pstrb[k] && (paddr[2] ? k + ood_pkg::LANES : k) < ood_pkg::INSTR_BYTES) begin
              ibyte[paddr[2] ? k + ood_pkg::LANES : k] <= pwdata[k*ood_pkg::BYTE_W +: 8];
            end
          end
        end
        ood_pkg::OFF_BASES: begin
          base_register <= merge16(base_register, pwdata[15:0], pstrb[1:0]);
          base_pointer <= merge16(base_pointer, pwdata[31:16], pstrb[3:2]);
        end
        ood_pkg::OFF_INDEX: begin
          source_index <= merge16(source_index, pwdata[15:0], pstrb[1:0]);
          destination_index <= merge16(destination_index, pwdata[31:16], pstrb[3:2]);
        end
        ood_pkg::OFF_COUNT: begin
          count_register <= merge16(count_register, pwdata[15:0], pstrb[1:0]);
        end
        default: ;
      endcase
    end
  end

  always_comb begin
    next_prdata = '0;
    next_slverr = 1'b0;
    case (paddr)
      ood_pkg::OFF_INSTR_LO: next_prdata = {ibyte[3], ibyte[2], ibyte[1], ibyte[0]};
      ood_pkg::OFF_INSTR_HI: next_prdata = {16'h0000, ibyte[5], ibyte[4]};
      ood_pkg::OFF_BASES: next_prdata = {base_pointer, base_register};
      ood_pkg::OFF_INDEX: next_prdata = {destination_index, source_index};
      ood_pkg::OFF_COUNT: next_prdata = {16'h0000, count_register};
      ood_pkg::OFF_CTRL: next_prdata = '0;
      ood_pkg::OFF_FLAGS: next_prdata = {16'h0000, processor_flag_word};
      ood_pkg::OFF_EADDR: next_prdata = {16'h0000, dec.eff_addr};
      ood_pkg::OFF_OPERAND: next_prdata = {dec.imm_val, dec.shift_count,
                                           dec.reg_id, dec.rm_id};
      ood_pkg::OFF_STATUS: next_prdata = {11'h000, state, pend_rep, pend_seg_v, pend_lock,
                                          dec.disp_len, dec.imm_len, dec.word_op,
                                          dec.to_reg, dec.rm_is_reg, dec.esc_op,
                                          dec.invalid, dec.jump_taken, dec.rep_go,
                                          dec.seg_valid, dec.seg, dec.lock,
                                          dec.step_back};
      default: next_slverr = 1'b1;
    endcase
  end

  // one wait state keeps read data and error straight from flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= '0;
      pslverr <= 1'b0;
    end else if (ce) begin
      pready <= psel & penable & ~pready;
      if (psel && penable && !pready) begin
        prdata <= pwrite ? 32'h0000_0000 : next_prdata;
        pslverr <= next_slverr;
      end else begin
        pslverr <= 1'b0;
      end
    end
  end

  a_carry_clear: assert property (@(posedge pclk) disable iff (!presetn)
    go_ok && op == ood_pkg::CARRY_CLEAR_OP |=> !processor_flag_word[ood_pkg::FLAG_CARRY])
    else $error("carry not cleared");
  a_carry_invert: assert property (@(posedge pclk) disable iff (!presetn)
    go_ok && op == ood_pkg::CARRY_INVERT_OP |=> processor_flag_word[ood_pkg::FLAG_CARRY]
      != $past(processor_flag_word[ood_pkg::FLAG_CARRY]))
    else $error("carry not inverted");
  a_dir_set: assert property (@(posedge pclk) disable iff (!presetn)
    go_ok && op == ood_pkg::DIRECTION_SET_OP |=> processor_flag_word[ood_pkg::FLAG_DIR])
    else $error("direction not set");
  a_int_clear: assert property (@(posedge pclk) disable iff (!presetn)
    go_ok && op == ood_pkg::INT_ENABLE_CLEAR_OP |=> !processor_flag_word[ood_pkg::FLAG_INTEN])
    else $error("interrupt enable not cleared");
  a_halt_enter: assert property (@(posedge pclk) disable iff (!presetn)
    go_ok && op == ood_pkg::HALT_OP |=> cpu_halted && state == ood_pkg::RUN_HALTED)
    else $error("halt not entered");
  a_disp_byte: assert property (@(posedge pclk) disable iff (!presetn)
    go_ok && has_modrm && !is_prefix && mrm.md == ood_pkg::MOD_DISP8
      |=> dec.disp_len == 2'h1 && !dec.rm_is_reg)
    else $error("byte displacement length wrong");
  a_reg_operand: assert property (@(posedge pclk) disable iff (!presetn)
    go_ok && has_modrm && !is_prefix && mrm.md == ood_pkg::MOD_REG
      |=> dec.rm_is_reg && dec.disp_len == 2'h0)
    else $error("register operand not flagged");
  a_movcs_reject: assert property (@(posedge pclk) disable iff (!presetn)
    go_ok && op == ood_pkg::MOV_SEG_OP && mrm.rg == ood_pkg::MOVSEG_CODE |=> dec.invalid)
    else $error("code segment load not rejected");
  a_lock_once: assert property (@(posedge pclk) disable iff (!presetn)
    ce && done_wr && !go_ok |=> !bus_lock ##1 (!bus_lock || $past(go_ok)))
    else $error("lock outlived its instruction");
  a_esc_form: assert property (@(posedge pclk) disable iff (!presetn)
    go_ok && (op & ood_pkg::ESC_MASK) == ood_pkg::ESC_PAT |=> dec.esc_op)
    else $error("escape not decoded");
endmodule : ood_decoder

// ==== ood_test_src.sv ====
`timescale 1ns/10ps
module ood_test_src #(parameter int DLY = 4) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic arm,
  output logic test_ready
);
  int cnt;
  // comes true a while after arming, never at once, so waiting is seen
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) cnt <= 0;
    else cnt <= arm ? cnt + 1 : 0;
  end
  assign test_ready = (cnt >= DLY);
endmodule : ood_test_src

// ==== cpu_opcode_operand_decoder_bench.sv ====
`timescale 1ns/10ps
`define CHK(nm, e, s) begin checks++; if ((s) !== (e)) begin n_fail++; \
  $display("CHECK FAILED %s exp %h got %h", nm, e, s); end end
module cpu_opcode_operand_decoder_bench;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, arm = 0, err;
  logic [7:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic pready, pslverr, bus_lock, cpu_halted, test_ready;
  int n_fail = 0, checks = 0;
  logic [7:0] fop [8] = '{8'hf9, 8'hf5, 8'hf5, 8'hf8, 8'hfd, 8'hfb, 8'hfc, 8'hfa};
  logic [15:0] fexp [8] = '{16'h0001, 16'h0000, 16'h0001, 16'h0000, 16'h0400, 16'h0600,
    16'h0200, 16'h0000};
  logic [31:0] ins [5] = '{32'h00fe408b, 32'h1000838b, 32'h1234068b, 32'h0005478b,
    32'h0080448b};
  logic [15:0] eexp [5] = '{16'h020e, 16'h1320, 16'h1234, 16'h0205, 16'hff90};
  always #4 pclk = ~pclk;
  ood_decoder dut_u (.pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf),
    .test_ready(test_ready), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .bus_lock(bus_lock), .cpu_halted(cpu_halted));
  ood_test_src #(.DLY(4)) src_u (.pclk(pclk), .presetn(presetn), .arm(arm),
    .test_ready(test_ready));
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
  task automatic go(input logic [31:0] w);
    xfer(1'b1, ood_pkg::OFF_INSTR_LO, w);
    xfer(1'b1, ood_pkg::OFF_CTRL, 32'h00000001);
  endtask : go
  task automatic go_rd(input logic [31:0] w, input logic [7:0] a);
    go(w);
    xfer(1'b0, a, 32'h0);
  endtask : go_rd
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : stop_test
  initial begin
    #200000;
    n_fail++;
    stop_test();
  end
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    xfer(1'b0, ood_pkg::OFF_FLAGS, 32'h0);
    `CHK("flag reset", 16'h0000, rd[15:0])
    for (int i = 0; i < 8; i++) begin
      go({24'h0, fop[i]});
      xfer(1'b0, ood_pkg::OFF_FLAGS, 32'h0);
      `CHK("flag op", fexp[i], rd[15:0])
    end
    xfer(1'b1, ood_pkg::OFF_FLAGS, 32'h0000ffff);
    xfer(1'b0, ood_pkg::OFF_FLAGS, 32'h0);
    `CHK("flag layout", 16'h0fd5, rd[15:0])
    $display("test flags done");
    xfer(1'b1, ood_pkg::OFF_BASES, 32'h03000200);
    xfer(1'b1, ood_pkg::OFF_INDEX, 32'h00200010);
    for (int i = 0; i < 5; i++) begin
      go(ins[i]);
      xfer(1'b0, ood_pkg::OFF_EADDR, 32'h0);
      `CHK("eff addr", eexp[i], rd[15:0])
    end
    go(32'h0000c38b);
    xfer(1'b0, ood_pkg::OFF_OPERAND, 32'h0);
    `CHK("reg ids", 8'h8b, rd[7:0])
    go(32'h00fec083);
    xfer(1'b0, ood_pkg::OFF_OPERAND, 32'h0);
    `CHK("imm sext", 16'hfffe, rd[31:16])
    go_rd(32'h123406dd, ood_pkg::OFF_STATUS);
    `CHK("escape", 1'b1, rd[8])
    xfer(1'b0, 8'h40, 32'h0);
    `CHK("unmapped err", 1'b1, err)
    go_rd(32'h0000c88e, ood_pkg::OFF_STATUS);
    `CHK("cs load", 1'b1, rd[7])
    `CHK("dir width", 2'h1, rd[11:10])
    xfer(1'b1, ood_pkg::OFF_COUNT, 32'h00000005);
    go_rd(32'h0000e0d3, ood_pkg::OFF_OPERAND);
    `CHK("shift count reg", 8'h05, rd[15:8])
    go_rd(32'h0000e0d1, ood_pkg::OFF_OPERAND);
    `CHK("shift count one", 8'h01, rd[15:8])
    xfer(1'b1, ood_pkg::OFF_INSTR_HI, 32'h0000beef);
    go_rd(32'h12348081, ood_pkg::OFF_OPERAND);
    `CHK("imm after disp", 16'hbeef, rd[31:16])
    xfer(1'b0, ood_pkg::OFF_STATUS, 32'h0);
    `CHK("disp imm len", 4'ha, rd[15:12])
    go_rd(32'h0000003e, ood_pkg::OFF_STATUS);
    `CHK("seg pending", 1'b1, rd[17])
    go_rd(32'h0000c38b, ood_pkg::OFF_STATUS);
    `CHK("seg applied", 3'h7, rd[4:2])
    `CHK("seg consumed", 1'b0, rd[17])
    go(32'h000000f3);
    go_rd(32'h000000a6, ood_pkg::OFF_STATUS);
    `CHK("rep equal", 1'b1, rd[5])
    go(32'h000000f2);
    go_rd(32'h000000ae, ood_pkg::OFF_STATUS);
    `CHK("rep unequal", 1'b0, rd[5])
    go_rd(32'h0000007d, ood_pkg::OFF_STATUS);
    `CHK("signed cond", 1'b1, rd[6])
    go_rd(32'h00000077, ood_pkg::OFF_STATUS);
    `CHK("unsigned cond", 1'b0, rd[6])
    $display("test operands done");
    go(32'h000000f0);
    go_rd(32'h000000f8, ood_pkg::OFF_STATUS);
    `CHK("lock on", 1'b1, bus_lock)
    `CHK("lock field", 1'b1, rd[1])
    xfer(1'b1, ood_pkg::OFF_CTRL, 32'h00000002);
    xfer(1'b0, ood_pkg::OFF_STATUS, 32'h0);
    `CHK("lock off", 1'b0, bus_lock)
    `CHK("lock field off", 1'b0, rd[1])
    go_rd(32'h000000f4, ood_pkg::OFF_STATUS);
    `CHK("halted", 1'b1, cpu_halted)
    `CHK("halt state", 2'h1, rd[20:19])
    xfer(1'b1, ood_pkg::OFF_CTRL, 32'h00000004);
    xfer(1'b0, ood_pkg::OFF_STATUS, 32'h0);
    `CHK("resumed", 1'b0, cpu_halted)
    go_rd(32'h0000009b, ood_pkg::OFF_STATUS);
    `CHK("waiting", 2'h2, rd[20:19])
    arm <= 1'b1;
    repeat (8) @(posedge pclk);
    xfer(1'b0, ood_pkg::OFF_STATUS, 32'h0);
    `CHK("wait over", 2'h0, rd[20:19])
    $display("test control done");
    stop_test();
  end
endmodule : cpu_opcode_operand_decoder_bench
